// file: bench/sent_rx_model.sv
// Receiver-side model that paces frames and slow message requests
`timescale 1ns/1ps
module sent_rx_model (
  input  wire logic        clk,         // Clock
  output logic             frame_start, // Frame strobe to encoder
  output logic             slow_req,    // Slow message request
  output logic      [7:0]  slow_id,     // Requested identifier
  input  wire logic [1:0]  status_bits, // Status nibble bits
  input  wire logic [11:0] fast_value,  // Fast-channel value
  input  wire logic        slow_ack,    // Answer strobe
  input  wire logic        slow_ok,     // Identifier served
  input  wire logic [11:0] slow_data    // Slow payload
);
  initial begin
    frame_start = 1'b0;
    slow_req    = 1'b0;
    slow_id     = 8'h00;
  end

  // Status nibble is taken as sent; the checksum gives it no
  task automatic frame(output logic [1:0] st, output logic [11:0] fv);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    #1;
    st = status_bits;
    fv = fast_value;
  endtask : frame

  // Identifier is scrambled after the request so a stale value never helps
  task automatic ask(input logic [7:0] id, output logic [13:0] ans);
    @(posedge clk);
    slow_req <= 1'b1;
    slow_id  <= id;
    @(posedge clk);
    slow_req <= 1'b0;
    slow_id  <= ~id;
    #1;
    ans = {slow_ack, slow_ok, slow_data};
  endtask : ask
endmodule : sent_rx_model

// file: bench/tb_top.sv
// Self-checking bench for the SENT diagnostic encoder
`timescale 1ns/1ps
`include "sent_diag_consts.svh"
module tb_top;
  import sent_diag_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] angle, fast_value, slow_data, fv;
  logic [7:0] temp_code, slow_id;
  logic [8:0] supply_code;
  logic [10:0] safety_err;
  logic nvm_valid, nvm_last, frame_start, slow_req, slow_ack, slow_ok;
  logic nvm_done, er;
  logic [`NVM_W-1:0] nvm_word;
  logic [1:0] status_bits, st;
  logic [13:0] ans;
  int mismatches, compares, cycles;
  typedef struct packed {
    logic [6:0] ctrl; logic [11:0] ang; logic [10:0] saf;
    logic [8:0] sup; logic [7:0] tmp; logic [1:0] st;
    logic [11:0] fast; logic [11:0] code;
  } row_t;
  row_t rows[14];
  logic [7:0] ra[6];
  logic [31:0] rv[6];

  sent_diag_encoder #(.AREA_COUNT(4)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .angle(angle), .temp_code(temp_code),
    .supply_code(supply_code), .safety_err(safety_err),
    .nvm_valid(nvm_valid), .nvm_word(nvm_word), .nvm_last(nvm_last),
    .frame_start(frame_start), .status_bits(status_bits),
    .fast_value(fast_value), .slow_req(slow_req), .slow_id(slow_id),
    .slow_ack(slow_ack), .slow_ok(slow_ok), .slow_data(slow_data),
    .nvm_done(nvm_done));
  sent_rx_model rx (
    .clk(clk), .frame_start(frame_start), .slow_req(slow_req),
    .slow_id(slow_id), .status_bits(status_bits), .fast_value(fast_value),
    .slow_ack(slow_ack), .slow_ok(slow_ok), .slow_data(slow_data));

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run needs a few hundred cycles; far beyond that means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Wide enough to carry the error flag beside a full read word
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  function automatic logic [`NVM_W-1:0] enc(input logic [15:0] d);
    logic [`NVM_W-1:0] w;
    int j;
    w = '0;
    j = 0;
    for (int p = 3; p < `NVM_W; p++) if ((p & (p - 1)) != 0) begin
      w[p] = d[j];
      j++;
    end
    for (int k = 0; k < `SYN_W; k++)
      for (int p = 3; p < `NVM_W; p++) if (p[k]) w[1 << k] ^= w[p];
    w[0] = ^w[`NVM_W-1:1];
    return w;
  endfunction : enc
  task automatic nvm(input logic [15:0] d, input logic last,
                     input logic [`NVM_W-1:0] flip);
    @(posedge clk);
    nvm_valid <= 1'b1; nvm_word <= enc(d) ^ flip; nvm_last <= last;
    @(posedge clk);
    nvm_valid <= 1'b0; nvm_word <= ~(enc(d) ^ flip); nvm_last <= 1'b0;
  endtask : nvm

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, psel, penable, pwrite, nvm_valid, nvm_last} = 6'b10_0000;
    {paddr, pwdata, nvm_word, cycles} = '0;
    {angle, temp_code, supply_code, safety_err} = {12'h400, 8'h40, 9'h100,
                                                    11'h000};
    mismatches = 0; compares = 0;
    rows = '{'{7'h04,12'h400,11'h000,9'h100,8'h40,2'd0,12'h400,12'h000},
      '{7'h04,12'h400,11'h001,9'h100,8'h40,2'd1,12'hFFF,12'h801},
      '{7'h14,12'h400,11'h001,9'h100,8'h40,2'd1,12'h400,12'h801},
      '{7'h24,12'h400,11'h001,9'h100,8'h40,2'd1,12'hFFA,12'h801},
      '{7'h34,12'h400,11'h001,9'h100,8'h40,2'd1,12'hFFA,12'h801},
      '{7'h44,12'h400,11'h001,9'h100,8'h40,2'd1,12'hFFA,12'h801},
      '{7'h05,12'h400,11'h001,9'h100,8'h40,2'd0,12'hFFF,12'h801},
      '{7'h04,12'h900,11'h000,9'h100,8'h40,2'd2,12'h900,12'h001},
      '{7'h06,12'h900,11'h000,9'h100,8'h40,2'd0,12'h900,12'h001},
      '{7'h04,12'h050,11'h000,9'h100,8'h40,2'd2,12'h050,12'h002},
      '{7'h04,12'h900,11'h004,9'h100,8'h40,2'd1,12'hFFF,12'h804},
      '{7'h04,12'h400,11'h000,9'h050,8'h40,2'd2,12'h400,12'h020},
      '{7'h04,12'h400,11'h000,9'h1A0,8'h40,2'd2,12'h400,12'h021},
      '{7'h04,12'h400,11'h000,9'h100,8'h90,2'd2,12'h400,12'h022}};
    ra = '{`A_CTRL, `A_RANGE, `A_SUPPLY, `A_TEMP, `A_IRQ_ST, `A_IRQ_MASK};
    rv = '{32'h0000_0004, 32'h0000_0FFF, 32'h01FF_0000, 32'h0000_00FF,
           32'h0000_0000, 32'h0000_0000};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({status_bits, fast_value, irq, nvm_done}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    apb(1'b1, `A_RANGE, 32'h0100_0800);
    apb(1'b1, `A_SUPPLY, 32'h0180_0080);
    apb(1'b1, `A_TEMP, 32'h0000_0080);
    foreach (rows[i]) begin
      apb(1'b1, `A_CTRL, {25'h0, rows[i].ctrl});
      angle <= rows[i].ang; safety_err <= rows[i].saf;
      supply_code <= rows[i].sup; temp_code <= rows[i].tmp;
      repeat (3) @(posedge clk);
      rx.frame(st, fv);
      chk(st, rows[i].st);
      chk(fv, rows[i].fast);
      rx.ask(`ID_DIAG, ans);
      chk(ans, {2'b11, rows[i].code});
    end
    // ****************************************
    // Slow channel contents and refusals
    // ****************************************
    {angle, safety_err, supply_code, temp_code} <= {12'h400, 11'h0,
                                                     9'h100, 8'hAB};
    apb(1'b1, `A_CTRL, 32'h0000_000C);
    rx.ask(`ID_SLOT, ans);
    chk(ans, {2'b11, `SLOT_ONE});
    rx.ask(`ID_TEMP, ans);
    chk(ans, {2'b11, 12'h0AB});
    apb(1'b1, `A_CTRL, 32'h0000_0000);
    rx.ask(`ID_SLOT, ans);
    chk(ans, {2'b11, `SLOT_ZERO});
    rx.ask(`ID_DIAG, ans);
    chk(ans, 14'h2000);
    rx.ask(8'h02, ans);
    chk(ans, 14'h2000);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `A_CODE0 + 8'(4 * i), 32'h0000_0A50 + i);
      apb(1'b0, `A_CODE0 + 8'(4 * i), 32'h0);
      chk(rd, 32'h0000_0A50 + i);
      rx.ask(`ID_CODE0 + 8'(i), ans);
      chk(ans, {2'b11, 12'hA50 + 12'(i)});
    end
    // ****************************************
    // NVM pass, interrupt and bit errors
    // ****************************************
    apb(1'b1, `A_CTRL, 32'h0000_0004);
    apb(1'b1, `A_TEMP, 32'h0000_00FF);
    apb(1'b1, `A_IRQ_ST, 32'h0000_001F);
    for (int a = 0; a < 4; a++) begin
      nvm(16'h1234, 1'b0, '0);
      nvm(16'h1234, 1'b1, '0);
    end
    repeat (2) @(posedge clk);
    #1;
    chk({nvm_done, irq}, 2'b10);
    apb(1'b0, `A_STATE, 32'h0);
    chk(rd & 32'h3F, 32'h04);
    apb(1'b1, `A_IRQ_MASK, 32'h0000_0010);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    apb(1'b1, `A_IRQ_ST, 32'h0000_0010);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    nvm(16'h00FF, 1'b0, 22'h00_0020);
    repeat (3) @(posedge clk);
    rx.frame(st, fv);
    chk({st, fv}, {2'b10, 12'h400});
    rx.ask(`ID_DIAG, ans);
    chk(ans, {2'b11, `DC_SINGLE});
    nvm(16'h00FF, 1'b0, 22'h00_0060);
    repeat (3) @(posedge clk);
    rx.frame(st, fv);
    chk({st, fv}, {2'b01, `FAST_A});
    rx.ask(`ID_DIAG, ans);
    chk(ans, {2'b11, 12'h800});
    apb(1'b0, `A_IRQ_ST, 32'h0);
    chk(rd[1:0], 2'b11);
    // ****************************************
    // Second reset, bad area checksums
    // ****************************************
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({status_bits, fast_value, irq, nvm_done}, 32'h0);
    for (int a = 0; a < 4; a++) begin
      nvm(16'h1234, 1'b0, '0);
      nvm(16'h1235, 1'b1, '0);
    end
    repeat (3) @(posedge clk);
    rx.frame(st, fv);
    chk({st, fv}, {2'b01, `FAST_A});
    apb(1'b0, `A_STATE, 32'h0);
    chk(rd & 32'h3F, 32'h25);
    conclude();
  end
endmodule : tb_top

// file: logic/nvm_word_check.sv
// Single-error-correct, double-error-detect decoder for one NVM word
`timescale 1ns/1ps
`include "sent_diag_consts.svh"
module nvm_word_check (
  input  wire logic [`NVM_W-1:0]      word,   // Protected word, bit 0 parity
  output logic      [`NVM_DATA_W-1:0] data,   // Corrected data
  output logic                        single, // Single error corrected
  output logic                        double  // Uncorrectable error
);
  logic [`SYN_W-1:0]  syn;
  logic               par;
  logic [`NVM_W-1:0]  fixed;
  int                 k;

  always_comb begin
    syn    = '0;
    fixed  = word;
    data   = '0;
    k      = 0;
    for (int i = 1; i < `NVM_W; i++) begin
      if (word[i]) begin
        syn = syn ^ `SYN_W'(i);
      end
    end
    par    = ^word;
    // Overall parity odd means one flipped bit, even with a syndrome means two
    single = par && (int'(syn) < `NVM_W);
    double = (syn != '0 && !par) || (int'(syn) >= `NVM_W);
    if (single && syn != '0) begin
      fixed[syn] = ~word[syn];
    end
    for (int i = 1; i < `NVM_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        data[k[3:0]] = fixed[i];
        k = k + 1;
      end
    end
  end
endmodule : nvm_word_check

// file: logic/sent_diag_consts.svh
// Constants of the SENT diagnostic and slow-channel encoder
`ifndef SENT_DIAG_CONSTS_SVH
`define SENT_DIAG_CONSTS_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define A_CTRL      8'h00
`define A_RANGE     8'h04
`define A_SUPPLY    8'h08
`define A_TEMP      8'h0C
`define A_IRQ_ST    8'h10
`define A_IRQ_MASK  8'h14
`define A_STATE     8'h18
`define A_CODE0     8'h20
`define A_CODE7     8'h3C
// ****************************************
// Reset values
// ****************************************
`define RST_CTRL    7'h04
`define RST_UPPER   12'hF_FF
`define RST_LOWER   12'h0_00
`define RST_SUP_LO  9'h0_00
`define RST_SUP_HI  9'h1_FF
`define RST_TEMP    8'hFF
// ****************************************
// Slow message identifiers and codes
// ****************************************
`define ID_DIAG     8'h01
`define ID_TEMP     8'h23
`define ID_SLOT     8'h29
`define ID_CODE0    8'h90
`define ID_CODE7    8'h97
`define DC_NONE     12'h0_00
`define DC_UPPER    12'h0_01
`define DC_LOWER    12'h0_02
`define DC_UNDER    12'h0_20
`define DC_OVER     12'h0_21
`define DC_TEMP     12'h0_22
`define DC_SINGLE   12'h0_23
`define SLOT_ZERO   12'h0_00
`define SLOT_ONE    12'hF_FF
// ****************************************
// Fast-channel diagnostic values, NVM word
// ****************************************
`define FAST_A      12'hF_FF
`define FAST_H      12'hF_FA
`define NVM_W       22
`define NVM_DATA_W  16
`define SYN_W       5
`endif

// file: logic/sent_diag_encoder.sv
// SENT status nibble, fast diagnostic value and slow message source
`timescale 1ns/1ps
`include "sent_diag_consts.svh"
module sent_diag_encoder
  import sent_diag_pkg::*;
#(
  parameter int AREA_COUNT = 4
) (
  input  wire logic                  clk,         // 20 MHz clock
  input  wire logic                  rst,         // Sync reset, high
  input  wire logic                  psel,        // APB select
  input  wire logic                  penable,     // APB enable
  input  wire logic                  pwrite,      // APB write
  input  wire logic [7:0]            paddr,       // APB byte address
  input  wire logic [31:0]           pwdata,      // APB write data
  output logic      [31:0]           prdata,      // APB read data
  output logic                       pready,      // APB ready
  output logic                       pslverr,     // APB error
  output logic                       irq,         // Interrupt level
  input  wire logic [11:0]           angle,       // Angular value
  input  wire logic [7:0]            temp_code,   // Temperature code
  input  wire logic [8:0]            supply_code, // Supply voltage code
  input  wire logic [10:0]           safety_err,  // Safety check failures
  input  wire logic                  nvm_valid,   // NVM word strobe
  input  wire logic [`NVM_W-1:0]     nvm_word,    // Protected NVM word
  input  wire logic                  nvm_last,    // Word is area checksum
  input  wire logic                  frame_start, // New frame strobe
  output logic      [1:0]            status_bits, // Status nibble bits
  output logic      [11:0]           fast_value,  // Fast-channel value
  input  wire logic                  slow_req,    // Slow message request
  input  wire logic [7:0]            slow_id,     // Requested identifier
  output logic                       slow_ack,    // Answer strobe
  output logic                       slow_ok,     // Identifier is served
  output logic      [11:0]           slow_data,   // Slow message payload
  output logic                       nvm_done     // Checksum pass finished
);
  state_t                  st_q;
  state_t                  st_d;
  logic [`NVM_DATA_W-1:0]  w_data;
  logic                    w_single;
  logic                    w_double;
  logic                    wr;
  logic                    rd_hit;
  logic                    pw_now;
  logic [4:0]              ev;
  logic [11:0]             code_now;
  logic [2:0]              ci;

  nvm_word_check u_check (
    .word   (nvm_word),
    .data   (w_data),
    .single (w_single),
    .double (w_double)
  );

  assign wr      = psel && penable && pwrite;
  assign pready  = psel && penable;
  assign irq     = |(st_q.irq_st & st_q.irq_mask);
  assign nvm_done    = (st_q.nvm == NVM_RUN);
  assign status_bits = st_q.status;
  assign fast_value  = st_q.fast;
  assign slow_ack    = st_q.ack;
  assign slow_ok     = st_q.ok;
  assign slow_data   = st_q.sdata;

  // ****************************************
  // Pre-warning causes and status code
  // ****************************************
  always_comb begin
    pw_now = (angle > st_q.upper) || (angle < st_q.lower) ||
             st_q.sgl || (temp_code > st_q.temp_thr) ||
             (supply_code > st_q.sup_hi) || (supply_code < st_q.sup_lo);
    if (st_q.diag) begin
      code_now = {1'b1, safety_err};
    end else if (angle > st_q.upper) begin
      code_now = `DC_UPPER;
    end else if (angle < st_q.lower) begin
      code_now = `DC_LOWER;
    end else if (supply_code < st_q.sup_lo) begin
      code_now = `DC_UNDER;
    end else if (supply_code > st_q.sup_hi) begin
      code_now = `DC_OVER;
    end else if (temp_code > st_q.temp_thr) begin
      code_now = `DC_TEMP;
    end else if (st_q.sgl) begin
      code_now = `DC_SINGLE;
    end else begin
      code_now = `DC_NONE;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  always_comb begin
    prdata  = '0;
    rd_hit  = 1'b1;
    ci      = paddr[4:2];
    if (paddr >= `A_CODE0 && paddr <= `A_CODE7 && paddr[1:0] == 2'b00) begin
      prdata[11:0] = st_q.code[ci];
    end else begin
      unique case (paddr)
        `A_CTRL:     prdata[6:0] = st_q.cfg;
        `A_RANGE:    prdata = {4'h0, st_q.lower, 4'h0, st_q.upper};
        `A_SUPPLY:   prdata = {7'h00, st_q.sup_hi, 7'h00, st_q.sup_lo};
        `A_TEMP:     prdata[7:0] = st_q.temp_thr;
        `A_IRQ_ST:   prdata[4:0] = st_q.irq_st;
        `A_IRQ_MASK: prdata[4:0] = st_q.irq_mask;
        `A_STATE:    prdata = {4'h0, st_q.dcode, 10'h000, st_q.crc,
                               st_q.dbl, st_q.sgl, nvm_done,
                               st_q.prewarn, st_q.diag};
        default:     rd_hit = 1'b0;
      endcase
    end
    pslverr = pready && !rd_hit;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    ev   = '0;
    // Register writes; an unmapped write is answered with pslverr only
    if (wr && rd_hit) begin
      if (paddr >= `A_CODE0) begin
        st_d.code[ci] = pwdata[11:0];
      end else begin
        unique case (paddr)
          `A_CTRL: begin
            st_d.cfg = cfg_t'(pwdata[6:0]);
          end
          `A_RANGE: begin
            st_d.upper = pwdata[11:0];
            st_d.lower = pwdata[27:16];
          end
          `A_SUPPLY: begin
            st_d.sup_lo = pwdata[8:0];
            st_d.sup_hi = pwdata[24:16];
          end
          `A_TEMP:     st_d.temp_thr = pwdata[7:0];
          `A_IRQ_MASK: st_d.irq_mask = pwdata[4:0];
          default: ;
        endcase
      end
    end
    // NVM words: checksum pass after reset, error correction always
    if (nvm_valid) begin
      if (w_single) begin
        st_d.sgl = 1'b1;
        ev[0]    = 1'b1;
      end
      if (w_double) begin
        st_d.dbl = 1'b1;
        ev[1]    = 1'b1;
      end
      if (st_q.nvm == NVM_CHECK) begin
        if (nvm_last) begin
          if (st_q.sum != w_data) begin
            st_d.crc = 1'b1;
            ev[2]    = 1'b1;
          end
          st_d.sum  = '0;
          st_d.area = st_q.area + 2'd1;
          if (int'(st_q.area) == AREA_COUNT - 1) begin
            st_d.nvm = NVM_RUN;
            ev[4]    = 1'b1;
          end
        end else begin
          st_d.sum = st_q.sum + w_data;
        end
      end
    end
    // Single registered flags; prewarning only outside diagnostic mode
    st_d.diag    = st_q.dbl || st_q.crc || (|safety_err);
    st_d.prewarn = pw_now && !st_q.diag;
    ev[3]        = st_d.prewarn && !st_q.prewarn;
    // Frame sample keeps status, fast value and code consistent
    if (frame_start) begin
      // Status bits go out apart from the fast value; checksum skips them
      st_d.status[0] = st_q.diag && !st_q.cfg.mask_diag;
      st_d.status[1] = st_q.prewarn && !st_q.cfg.mask_pw;
      st_d.dcode     = code_now;
      st_d.fast      = angle;
      if (st_q.diag) begin
        unique case (st_q.cfg.fmt)
          FMT_A3:                 st_d.fast = angle;
          FMT_H1, FMT_H3, FMT_H4: st_d.fast = `FAST_H;
          default:                st_d.fast = `FAST_A;
        endcase
      end
    end
    // Slow-channel answer, one cycle after the request
    st_d.ack   = slow_req;
    st_d.ok    = 1'b0;
    st_d.sdata = '0;
    if (slow_req) begin
      st_d.ok = 1'b1;
      if (slow_id >= `ID_CODE0 && slow_id <= `ID_CODE7) begin
        st_d.sdata = st_q.code[slow_id[2:0]];
      end else if (slow_id == `ID_TEMP) begin
        st_d.sdata = {4'h0, temp_code};
      end else if (slow_id == `ID_SLOT) begin
        st_d.sdata = st_q.cfg.slot ? `SLOT_ONE : `SLOT_ZERO;
      end else if (slow_id == `ID_DIAG && st_q.cfg.enhanced_serial_enable) begin
        st_d.sdata = st_q.dcode;
      end else begin
        st_d.ok = 1'b0;
      end
    end
    // Interrupt status: write one to clear, a new event wins
    if (wr && paddr == `A_IRQ_ST) begin
      st_d.irq_st = st_q.irq_st & ~pwdata[4:0];
    end
    st_d.irq_st = st_d.irq_st | ev;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q          <= '0;
      st_q.cfg      <= cfg_t'(`RST_CTRL);
      st_q.upper    <= `RST_UPPER;
      st_q.lower    <= `RST_LOWER;
      st_q.sup_lo   <= `RST_SUP_LO;
      st_q.sup_hi   <= `RST_SUP_HI;
      st_q.temp_thr <= `RST_TEMP;
      st_q.nvm      <= NVM_CHECK;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_DIAG_BIT: assert property (frame_start && st_q.diag &&
    !st_q.cfg.mask_diag |=> status_bits[0])
    else $error("Status bit 0 not set in diagnostic mode");
  AST_DIAG_MASK: assert property (frame_start && st_q.cfg.mask_diag
    |=> !status_bits[0])
    else $error("Masked diagnostic bit was sent");
  AST_PREWARN: assert property (frame_start && st_q.prewarn &&
    !st_q.cfg.mask_pw |=> status_bits[1])
    else $error("Pre-warning bit missing");
  AST_PW_MASK: assert property (frame_start && st_q.cfg.mask_pw
    |=> !status_bits[1])
    else $error("Masked pre-warning bit was sent");
  AST_FAST_A1: assert property (frame_start && st_q.diag &&
    st_q.cfg.fmt == FMT_A1 |=> fast_value == `FAST_A)
    else $error("Wrong diagnostic value for A.1");
  AST_FAST_H: assert property (frame_start && st_q.diag &&
    st_q.cfg.fmt inside {FMT_H1, FMT_H3, FMT_H4}
    |=> fast_value == `FAST_H)
    else $error("Wrong diagnostic value for H format");
  AST_ESP_OFF: assert property (slow_req && slow_id == `ID_DIAG &&
    !st_q.cfg.enhanced_serial_enable |=> slow_ack && !slow_ok)
    else $error("Status code sent without enhanced enable");
  AST_SLOT: assert property (slow_req && slow_id == `ID_SLOT
    |=> slow_ok && slow_data == ($past(st_q.cfg.slot) ?
        `SLOT_ONE : `SLOT_ZERO))
    else $error("Sensor slot message wrong");
  AST_TEMP: assert property (slow_req && slow_id == `ID_TEMP
    |=> slow_data == {4'h0, $past(temp_code)})
    else $error("Temperature message wrong");
  AST_DOUBLE: assert property (nvm_valid && w_double
    |-> ##2 st_q.diag [*3])
    else $error("Double error did not force diagnostic mode");
  AST_CODES: assert property (slow_req && slow_id[7:3] == 5'h12
    |=> slow_data == $past(st_q.code[slow_id[2:0]]))
    else $error("Customer code message wrong");
endmodule : sent_diag_encoder

// file: logic/sent_diag_pkg.sv
// Types shared by the SENT diagnostic encoder
package sent_diag_pkg;
  typedef enum logic [2:0] {FMT_A1, FMT_A3, FMT_H1, FMT_H3, FMT_H4} format_t;

  typedef struct packed {
    format_t fmt;
    logic    slot;
    logic    enhanced_serial_enable;
    logic    mask_pw;
    logic    mask_diag;
  } cfg_t;

  typedef enum logic {NVM_CHECK, NVM_RUN} nvm_state_t;

  typedef struct packed {
    cfg_t             cfg;
    logic [11:0]      upper;
    logic [11:0]      lower;
    logic [8:0]       sup_lo;
    logic [8:0]       sup_hi;
    logic [7:0]       temp_thr;
    logic [7:0][11:0] code;
    logic [4:0]       irq_st;
    logic [4:0]       irq_mask;
    nvm_state_t       nvm;
    logic [15:0]      sum;
    logic [1:0]       area;
    logic             sgl;
    logic             dbl;
    logic             crc;
    logic             diag;
    logic             prewarn;
    logic [1:0]       status;
    logic [11:0]      fast;
    logic [11:0]      dcode;
    logic             ack;
    logic             ok;
    logic [11:0]      sdata;
  } state_t;
endpackage : sent_diag_pkg
